/* hdl/fbm_io_table_mapper.sv */
// fbm_io_table_mapper: fieldbus slave process image, tables and status
`timescale 1ns/1ps
// Function
// (RQ1) answer master requests only, never initiate
// (RQ2) work at any master line rate
// (RQ3) status change queues a diagnostic report
// (RQ4) direct table access, arbitrated per cycle
// (RQ5) master output lands at offset zero
// (RQ6) master input read from offset zero
// (RQ7) bytes pass through uninterpreted
// (RQ8) optional swap inside each 16-bit word
// (RQ9) optional 12-byte status header in front
// (RQ10) header holds six 16-bit status fields
// (RQ11) first output word is command, data follows
// (RQ12) command bit 0 selects run or idle
// (RQ13) command bit 1 clears latched faults
// (RQ14) bit 4 resets module; others ignored
// (RQ15) indicator shows init, idle, run, fault, test
// (RQ16) fatal fault shown as countable flashes
// (RQ17) interface state codes offline, online, init
// (RQ18) seven sticky fault bits, upper bits zero
// (RQ19) fault clear also zeroes bus error count
// (RQ20) flash period is a block parameter
// (RQ21) command sampled per write, actions on rise
module fbm_io_table_mapper #(
  parameter int FLASH_HALF_CYC = fbm_pkg::FBM_FLASH_HALF_CYC
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  // fieldbus side: master output bytes
  input wire logic i_fb_wr_valid,
  input wire logic [7:0] i_fb_wr_data,
  input wire logic i_fb_wr_last,
  // fieldbus side: master input request and returned bytes
  input wire logic i_fb_rd_start,
  input wire logic [7:0] i_fb_rd_len,
  output logic o_fb_rd_valid,
  input wire logic i_fb_rd_ready,
  output logic [7:0] o_fb_rd_data,
  output logic o_fb_rd_last,
  // options
  input wire logic i_opt_swap,
  input wire logic i_opt_hdr,
  // vehicle network side table ports
  input wire logic i_nw_in_wr,
  input wire logic [fbm_pkg::FBM_ADDR_W-1:0] i_nw_in_addr,
  input wire logic [7:0] i_nw_in_data,
  output logic o_nw_in_ready,
  input wire logic i_nw_out_rd,
  input wire logic [fbm_pkg::FBM_ADDR_W-1:0] i_nw_out_addr,
  output logic o_nw_out_ready,
  output logic o_nw_out_valid,
  output logic [7:0] o_nw_out_data,
  // vehicle network status
  input wire logic [1:0] i_nw_state,
  input wire logic [fbm_pkg::FBM_FAULT_BITS-1:0] i_fault_evt,
  input wire logic i_bus_err_evt,
  input wire logic i_bus_off_evt,
  input wire logic i_rx_ovr_evt,
  // module state
  input wire logic i_init_done,
  input wire logic i_self_test,
  input wire logic i_major_fault,
  input wire logic [3:0] i_fault_id,
  output logic o_run,
  output logic o_fault_clear,
  output logic o_module_reset,
  output logic o_diag_pending,
  output logic [15:0] o_diag_status,
  input wire logic i_diag_ack,
  output logic o_led_red,
  output logic o_led_green
);
  import fbm_pkg::*;
  typedef enum logic [1:0] {
    RD_IDLE = 2'h1,
    RD_FETCH = 2'h2
  } fbm_rd_state_e;
  typedef struct packed {
    fbm_rd_state_e rd_st;
    logic [7:0] rd_idx;
    logic [7:0] rd_len;
    logic [7:0] wr_idx;
    logic cmd_load;
    logic run;
    logic fclr_prev;
    logic rst_prev;
    logic fclr_pulse;
    logic rst_pulse;
    logic [FBM_FAULT_BITS-1:0] faults;
    logic [15:0] err_cnt;
    logic [15:0] off_cnt;
    logic [15:0] ovr_cnt;
    logic [15:0] ms_prev;
    logic diag_pend;
    logic nw_out_valid;
    logic [7:0] nw_out_data;
  } fbm_map_state_s;
  fbm_map_state_s st;
  fbm_map_state_s next_st;
  logic [7:0] in_tbl [FBM_TBL_BYTES];
  logic [7:0] out_tbl [FBM_TBL_BYTES];
  logic [31:0] cmd_word;
  logic [15:0] ms_cur;
  logic [15:0] if_state;
  logic [15:0] fault_code_word;
  logic [95:0] hdr;
  logic [7:0] src_idx;
  logic [7:0] push_byte;
  logic push;
  logic push_last;
  logic fifo_ready;
  logic fb_in_access;
  logic [7:0] wr_addr;
  logic fclr;
  logic [8:0] fifo_out;

  // interface state field from the network engine state
  always_comb begin
    case (i_nw_state)
      FBM_NW_OFFLINE: if_state = FBM_IF_OFFLINE; // RQ17
      FBM_NW_ONLINE: if_state = FBM_IF_ONLINE;
      default: if_state = FBM_IF_INIT;
    endcase
  end

  assign fault_code_word = {9'h000, st.faults}; // RQ18
  always_comb begin
    ms_cur = 16'h0000;
    ms_cur[FBM_MS_RUN_BIT] = st.run;
    ms_cur[FBM_MS_ONLINE_BIT] = i_nw_state == FBM_NW_ONLINE;
    ms_cur[FBM_MS_FAULT_BIT] = |st.faults;
    ms_cur[FBM_MS_MAJOR_BIT] = i_major_fault;
    ms_cur[FBM_MS_INIT_BIT] = !i_init_done;
  end
  // little-endian header image, lowest field in lowest bytes
  assign hdr = {st.ovr_cnt, st.off_cnt, st.err_cnt, fault_code_word,
                if_state, ms_cur}; // RQ10

  // command word sits in the first four output-table bytes
  assign cmd_word = {out_tbl[3], out_tbl[2], out_tbl[1], out_tbl[0]}; // RQ11

  // fieldbus fetch: header overlays the front, table bytes pass unchanged
  assign src_idx = fbm_swap_idx(st.rd_idx, i_opt_swap); // RQ8
  always_comb begin
    if (i_opt_hdr && src_idx < FBM_HDR_BYTES) begin
      push_byte = hdr[{src_idx[3:0], 3'h0} +: 8]; // RQ9
    end else if (src_idx < 8'(FBM_TBL_BYTES)) begin
      push_byte = in_tbl[src_idx[FBM_ADDR_W-1:0]]; // RQ6 RQ7
    end else begin
      push_byte = 8'h00;
    end
  end
  // only a master request starts a fetch, at any line rate
  assign push = (st.rd_st == RD_FETCH) && fifo_ready; // RQ1 RQ2
  assign push_last = st.rd_idx == st.rd_len - 8'h01;
  // fieldbus wins the input table; network write waits while a fetch pushes
  assign fb_in_access = push; // RQ4
  assign o_nw_in_ready = !fb_in_access; // RQ4
  assign o_nw_out_ready = !i_fb_wr_valid; // RQ4
  assign wr_addr = fbm_swap_idx(st.wr_idx, i_opt_swap); // RQ8
  assign fclr = st.cmd_load && cmd_word[FBM_CMD_FCLR_BIT] && !st.fclr_prev;

  // next-state logic
  always_comb begin
    next_st = st;
    next_st.cmd_load = 1'b0;
    next_st.fclr_pulse = 1'b0;
    next_st.rst_pulse = 1'b0;
    next_st.nw_out_valid = 1'b0;
    case (st.rd_st)
      RD_IDLE: begin
        if (i_fb_rd_start && i_fb_rd_len != 8'h00) begin
          next_st.rd_st = RD_FETCH;
          next_st.rd_idx = 8'h00; // RQ6
          next_st.rd_len = i_fb_rd_len;
        end
      end
      RD_FETCH: begin
        if (push) begin
          next_st.rd_idx = st.rd_idx + 8'h01;
          if (push_last) begin
            next_st.rd_st = RD_IDLE;
          end
        end
      end
      default: next_st.rd_st = RD_IDLE;
    endcase
    // master write frame: index restarts at zero after its last byte
    if (i_fb_wr_valid) begin
      next_st.wr_idx = i_fb_wr_last ? 8'h00 : st.wr_idx + 8'h01; // RQ5
      next_st.cmd_load = i_fb_wr_last; // RQ21
    end
    // command decode once the frame is in the table
    if (st.cmd_load) begin
      next_st.run = cmd_word[FBM_CMD_RUN_BIT]; // RQ12
      next_st.fclr_prev = cmd_word[FBM_CMD_FCLR_BIT];
      next_st.rst_prev = cmd_word[FBM_CMD_RESET_BIT];
      next_st.fclr_pulse = fclr; // RQ13 RQ21
      next_st.rst_pulse = cmd_word[FBM_CMD_RESET_BIT] && !st.rst_prev; // RQ14
    end
    // sticky faults: a new event beats a same-cycle clear
    next_st.faults = (st.faults & ~{FBM_FAULT_BITS{fclr}}) | i_fault_evt; // RQ18
    if (fclr) begin
      next_st.err_cnt = {15'h0000, i_bus_err_evt}; // RQ19
    end else if (i_bus_err_evt && st.err_cnt != 16'hFFFF) begin
      next_st.err_cnt = st.err_cnt + 16'h0001;
    end
    if (i_bus_off_evt && st.off_cnt != 16'hFFFF) begin
      next_st.off_cnt = st.off_cnt + 16'h0001;
    end
    if (i_rx_ovr_evt && st.ovr_cnt != 16'hFFFF) begin
      next_st.ovr_cnt = st.ovr_cnt + 16'h0001;
    end
    // diagnostic report queued on any status change; change beats ack
    next_st.ms_prev = ms_cur;
    if (ms_cur != st.ms_prev) begin
      next_st.diag_pend = 1'b1; // RQ3
    end else if (i_diag_ack) begin
      next_st.diag_pend = 1'b0;
    end
    if (i_nw_out_rd && o_nw_out_ready) begin
      next_st.nw_out_valid = 1'b1; // RQ5
      next_st.nw_out_data = out_tbl[i_nw_out_addr];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      st <= '0;
      st.rd_st <= RD_IDLE;
      st.faults <= FBM_FAULT_RESET;
      st.err_cnt <= FBM_CNT_RESET;
      st.off_cnt <= FBM_CNT_RESET;
      st.ovr_cnt <= FBM_CNT_RESET;
    end else begin
      st <= next_st;
    end
  end

  // table storage: each table has one writer; the network write or read waits for the fieldbus side
  always_ff @(posedge i_mclk) begin
    if (i_fb_wr_valid && wr_addr < 8'(FBM_TBL_BYTES)) begin
      out_tbl[wr_addr[FBM_ADDR_W-1:0]] <= i_fb_wr_data; // RQ5 RQ7
    end
    if (i_nw_in_wr && o_nw_in_ready) begin
      in_tbl[i_nw_in_addr] <= i_nw_in_data; // RQ7
    end
  end

  // fifo decouples table fetch from the protocol engine's pace
  fbm_fifo #(
    .W(FBM_FIFO_W),
    .DEPTH(FBM_FIFO_DEPTH)
  ) u_ret_fifo (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_in_valid(push),
    .o_in_ready(fifo_ready),
    .i_in_data({push_last, push_byte}),
    .o_out_valid(o_fb_rd_valid),
    .i_out_ready(i_fb_rd_ready),
    .o_out_data(fifo_out)
  );
  assign o_fb_rd_data = fifo_out[7:0];
  assign o_fb_rd_last = fifo_out[8];

  fbm_led #(
    .HALF_CYC(FLASH_HALF_CYC)
  ) u_led (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_init(!i_init_done),
    .i_test(i_self_test),
    .i_major(i_major_fault),
    .i_run(st.run),
    .i_code(i_fault_id),
    .o_red(o_led_red),
    .o_green(o_led_green)
  );

  assign o_run = st.run;
  assign o_fault_clear = st.fclr_pulse;
  assign o_module_reset = st.rst_pulse;
  assign o_diag_pending = st.diag_pend;
  assign o_diag_status = st.ms_prev;
  assign o_nw_out_valid = st.nw_out_valid;
  assign o_nw_out_data = st.nw_out_data;

  no_unasked_push_a: assert property ( // RQ1
    @(posedge i_mclk) disable iff (i_srst)
    st.rd_st == RD_IDLE && !(i_fb_rd_start && i_fb_rd_len != 8'h00)
    |=> !push)
    else $error("fetch started without a master request");
  in_table_arb_a: assert property ( // RQ4
    @(posedge i_mclk) disable iff (i_srst)
    !(push && i_nw_in_wr && o_nw_in_ready))
    else $error("both sides touched the input table together");
  fetch_end_a: assert property ( // RQ6
    @(posedge i_mclk) disable iff (i_srst)
    push && push_last |=> st.rd_st == RD_IDLE)
    else $error("fetch ran past the requested length");
  hdr_first_a: assert property ( // RQ10
    @(posedge i_mclk) disable iff (i_srst)
    push && i_opt_hdr && !i_opt_swap && st.rd_idx == 8'h00
    |-> push_byte == ms_cur[7:0])
    else $error("header does not start with module status");
  run_follow_a: assert property ( // RQ12
    @(posedge i_mclk) disable iff (i_srst)
    st.cmd_load |=> st.run == $past(cmd_word[FBM_CMD_RUN_BIT]))
    else $error("run state does not follow command bit");
  reset_once_a: assert property ( // RQ14
    @(posedge i_mclk) disable iff (i_srst)
    st.cmd_load && cmd_word[FBM_CMD_RESET_BIT] && !st.rst_prev
    |=> o_module_reset ##1 !o_module_reset)
    else $error("module reset not a single pulse");
  fault_clear_a: assert property ( // RQ13
    @(posedge i_mclk) disable iff (i_srst)
    fclr && i_fault_evt == 7'h00 && !i_bus_err_evt
    |=> st.faults == 7'h00 && st.err_cnt == 16'h0000)
    else $error("fault clear left faults or error count");
  diag_raise_a: assert property ( // RQ3
    @(posedge i_mclk) disable iff (i_srst)
    ms_cur != st.ms_prev |=> o_diag_pending [*1])
    else $error("status change queued no diagnostic");
  cmd_sample_a: assert property ( // RQ21
    @(posedge i_mclk) disable iff (i_srst)
    i_fb_wr_valid && i_fb_wr_last |=> st.cmd_load && st.wr_idx == 8'h00)
    else $error("command not sampled after write frame");
endmodule : fbm_io_table_mapper

/* hdl/fbm_pkg.sv */
// fbm_pkg: constants, codes and helpers of the fieldbus I/O table mapper
package fbm_pkg;
  // table geometry
  localparam int FBM_TBL_BYTES = 64;
  localparam int FBM_ADDR_W = 6;
  localparam logic [7:0] FBM_HDR_BYTES = 8'h0C;
  localparam int FBM_CMD_BYTES = 4;
  // status header field byte offsets
  localparam logic [3:0] FBM_OFS_MODULE = 4'h0;
  localparam logic [3:0] FBM_OFS_IFSTATE = 4'h2;
  localparam logic [3:0] FBM_OFS_FAULT = 4'h4;
  localparam logic [3:0] FBM_OFS_ERRCNT = 4'h6;
  localparam logic [3:0] FBM_OFS_OFFCNT = 4'h8;
  localparam logic [3:0] FBM_OFS_OVRCNT = 4'hA;
  // command word bit positions
  localparam int FBM_CMD_RUN_BIT = 0;
  localparam int FBM_CMD_FCLR_BIT = 1;
  localparam int FBM_CMD_RESET_BIT = 4;
  // module status word bit positions
  localparam int FBM_MS_RUN_BIT = 0;
  localparam int FBM_MS_ONLINE_BIT = 1;
  localparam int FBM_MS_FAULT_BIT = 2;
  localparam int FBM_MS_MAJOR_BIT = 3;
  localparam int FBM_MS_INIT_BIT = 4;
  // vehicle network interface state inputs and header codes
  localparam logic [1:0] FBM_NW_OFFLINE = 2'h0;
  localparam logic [1:0] FBM_NW_ONLINE = 2'h1;
  localparam logic [15:0] FBM_IF_OFFLINE = 16'h8000;
  localparam logic [15:0] FBM_IF_ONLINE = 16'h8001;
  localparam logic [15:0] FBM_IF_INIT = 16'h8002;
  localparam int FBM_FAULT_BITS = 7;
  // reset values
  localparam logic [15:0] FBM_CNT_RESET = 16'h0000;
  localparam logic [6:0] FBM_FAULT_RESET = 7'h00;
  // return fifo
  localparam int FBM_FIFO_W = 9;
  localparam int FBM_FIFO_DEPTH = 16;
  // indicator timing
  localparam int FBM_CLK_HZ = 100_000_000;
  localparam int FBM_FLASH_HALF_MS = 500;
  localparam int FBM_FLASH_HALF_CYC = FBM_FLASH_HALF_MS * (FBM_CLK_HZ / 1000);
  localparam int FBM_FAULT_GAP = 4;

  // byte index within the table, optionally swapped on 16-bit boundaries
  function automatic logic [7:0] fbm_swap_idx(input logic [7:0] idx,
                                              input logic en);
    fbm_swap_idx = {idx[7:1], idx[0] ^ en};
  endfunction : fbm_swap_idx
endpackage : fbm_pkg

/* hdl/fbm_fifo.sv */
// fbm_fifo: parameterised valid/ready fifo on the input-data return path
`timescale 1ns/1ps
module fbm_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 16
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
  } fbm_fifo_s;
  fbm_fifo_s st;
  fbm_fifo_s next_st;
  logic [W-1:0] mem [DEPTH];
  logic full;
  logic empty;
  logic push;
  logic pop;

  // extra pointer bit tells full from empty
  assign full = (st.wr_ptr[AW-1:0] == st.rd_ptr[AW-1:0]) &&
                (st.wr_ptr[AW] != st.rd_ptr[AW]);
  assign empty = st.wr_ptr == st.rd_ptr;
  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = mem[st.rd_ptr[AW-1:0]];
  assign push = i_in_valid && !full;
  assign pop = i_out_ready && !empty;

  // pointer advance
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wr_ptr = st.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_st.rd_ptr = st.rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // storage has no reset; only pointers define content
  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem[st.wr_ptr[AW-1:0]] <= i_in_data;
    end
  end

  fifo_no_overflow_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    full && !pop |=> !o_in_ready)
    else $error("fifo accepted data while full");
endmodule : fbm_fifo

/* hdl/fbm_led.sv */
// fbm_led: module status indicator sequencer
`timescale 1ns/1ps
module fbm_led #(
  parameter int HALF_CYC = 50_000_000
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_init,
  input wire logic i_test,
  input wire logic i_major,
  input wire logic i_run,
  input wire logic [3:0] i_code,
  output logic o_red,
  output logic o_green
);
  import fbm_pkg::*;
  typedef enum logic [4:0] {
    LM_INIT = 5'h01,
    LM_IDLE = 5'h02,
    LM_RUN = 5'h04,
    LM_TEST = 5'h08,
    LM_FAULT = 5'h10
  } fbm_led_mode_e;
  typedef struct packed {
    logic [31:0] div;
    logic phase;
    logic [1:0] test_step;
    logic [5:0] seq;
    logic red;
    logic green;
  } fbm_led_s;
  fbm_led_s st;
  fbm_led_s next_st;
  fbm_led_mode_e mode;
  logic tick;
  logic [5:0] seq_end;

  // priority: power-up, self-test, fatal fault, then run/idle
  always_comb begin
    if (i_init) begin
      mode = LM_INIT;
    end else if (i_test) begin
      mode = LM_TEST;
    end else if (i_major) begin
      mode = LM_FAULT;
    end else if (i_run) begin
      mode = LM_RUN;
    end else begin
      mode = LM_IDLE;
    end
  end

  assign tick = st.div == 32'(HALF_CYC - 1); // RQ20
  // red/green pairs then a dark gap, so the code can be counted;
  // six bits so the longest code plus its gap does not wrap
  assign seq_end = 6'({i_code, 1'b0} + FBM_FAULT_GAP); // RQ16

  always_comb begin
    next_st = st;
    next_st.div = tick ? 32'h0000_0000 : st.div + 32'h0000_0001;
    if (tick) begin
      next_st.phase = !st.phase;
      next_st.test_step = (st.test_step == 2'h2) ? 2'h0 : st.test_step + 2'h1;
      next_st.seq = (st.seq >= seq_end - 6'h01) ? 6'h00 : st.seq + 6'h01;
    end
    case (mode)
      LM_INIT: begin
        next_st.red = 1'b1; // RQ15
        next_st.green = 1'b1;
      end
      LM_IDLE: begin
        next_st.red = 1'b0; // RQ15
        next_st.green = st.phase;
      end
      LM_RUN: begin
        next_st.red = 1'b0; // RQ15
        next_st.green = 1'b1;
      end
      LM_TEST: begin
        next_st.red = st.test_step != 2'h1; // RQ15
        next_st.green = st.test_step != 2'h0;
      end
      LM_FAULT: begin
        next_st.red = (st.seq < {1'b0, i_code, 1'b0}) && !st.seq[0]; // RQ16
        next_st.green = (st.seq < {1'b0, i_code, 1'b0}) && st.seq[0];
      end
      default: begin
        next_st.red = 1'b1;
        next_st.green = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_red = st.red;
  assign o_green = st.green;

  led_run_solid_a: assert property ( // RQ15
    @(posedge i_mclk) disable iff (i_srst)
    (mode == LM_RUN) [*2] |-> o_green && !o_red)
    else $error("run indicator not solid green");
  led_fault_pair_a: assert property ( // RQ16
    @(posedge i_mclk) disable iff (i_srst)
    (mode == LM_FAULT) [*2] |-> !(o_red && o_green))
    else $error("fault flash shows both colours");
endmodule : fbm_led

/* verif/fbm_master_model.sv */
// fbm_master_model: behavioural fieldbus master for cyclic i/o frames
`timescale 1ns/1ps
module fbm_master_model (
  input wire logic i_mclk,
  output logic o_wr_valid,
  output logic [7:0] o_wr_data,
  output logic o_wr_last,
  output logic o_rd_start,
  output logic [7:0] o_rd_len,
  input wire logic i_rd_valid,
  output logic o_rd_ready,
  input wire logic [7:0] i_rd_data,
  input wire logic i_rd_last
);
  // idle levels at time zero
  initial begin
    o_wr_valid = 1'b0;
    o_wr_data = 8'h5A;
    o_wr_last = 1'b0;
    o_rd_start = 1'b0;
    o_rd_len = 8'h00;
    o_rd_ready = 1'b0;
  end

  // one output frame, a byte per cycle; with i_opt_swap clear the first byte lands at offset zero
  task automatic send(input logic [7:0] b[$]);
    foreach (b[k]) begin
      @(posedge i_mclk);
      #1;
      o_wr_valid = 1'b1;
      o_wr_data = b[k];
      o_wr_last = (k == b.size() - 1);
    end
    @(posedge i_mclk);
    #1;
    o_wr_valid = 1'b0;
    o_wr_last = 1'b0;
    // released data line flips so a stale byte is never mistaken for data
    o_wr_data = ~o_wr_data;
  endtask : send

  // input request; a slow master holds ready low for stall cycles
  task automatic fetch(input int n, input int stall,
                       output logic [7:0] b[$], output logic ok);
    int t;
    b = {};
    ok = 1'b1;
    t = 0;
    @(posedge i_mclk);
    #1;
    o_rd_start = 1'b1;
    o_rd_len = 8'(n);
    @(posedge i_mclk);
    #1;
    o_rd_start = 1'b0;
    o_rd_len = ~o_rd_len;
    while (b.size() < n && t < 500) begin
      o_rd_ready = (t >= stall);
      @(posedge i_mclk);
      if (i_rd_valid && o_rd_ready) begin
        b.push_back(i_rd_data);
        if (i_rd_last !== (b.size() == n)) ok = 1'b0;
      end
      #1;
      t++;
    end
    o_rd_ready = 1'b0;
  endtask : fetch
endmodule : fbm_master_model

/* verif/fbm_io_table_mapper_bench.sv */
// fbm_io_table_mapper_bench: directed tests of the table mapper
`timescale 1ns/1ps
module fbm_io_table_mapper_bench;
  import fbm_pkg::*;
  localparam int HALF = 4;
  logic clk, rst, wv, wl, rs, rv, rr, rl, sw, hd, iw, ir, orr, oor, ov;
  logic [7:0] wd, rn, rd, idt, od;
  logic [FBM_ADDR_W-1:0] ia, oa;
  logic [1:0] ns;
  logic [FBM_FAULT_BITS-1:0] fe;
  logic be, bo, ro, idn, run, fc, mr, dp, da, red, grn, stt, mjf;
  logic [3:0] fid;
  logic [15:0] ds;
  logic [7:0] q[$];
  logic [7:0] e[$];
  logic ok;
  logic [7:0] d;
  int failures, checks_done, fc_n, mr_n;

  fbm_io_table_mapper #(.FLASH_HALF_CYC(HALF)) i_fbm_io_table_mapper (
    .i_mclk(clk), .i_srst(rst), .i_fb_wr_valid(wv), .i_fb_wr_data(wd),
    .i_fb_wr_last(wl), .i_fb_rd_start(rs), .i_fb_rd_len(rn),
    .o_fb_rd_valid(rv), .i_fb_rd_ready(rr), .o_fb_rd_data(rd),
    .o_fb_rd_last(rl), .i_opt_swap(sw), .i_opt_hdr(hd), .i_nw_in_wr(iw),
    .i_nw_in_addr(ia), .i_nw_in_data(idt), .o_nw_in_ready(ir),
    .i_nw_out_rd(orr), .i_nw_out_addr(oa), .o_nw_out_ready(oor),
    .o_nw_out_valid(ov), .o_nw_out_data(od), .i_nw_state(ns),
    .i_fault_evt(fe), .i_bus_err_evt(be), .i_bus_off_evt(bo),
    .i_rx_ovr_evt(ro), .i_init_done(idn), .i_self_test(stt),
    .i_major_fault(mjf), .i_fault_id(fid), .o_run(run),
    .o_fault_clear(fc), .o_module_reset(mr), .o_diag_pending(dp),
    .o_diag_status(ds), .i_diag_ack(da), .o_led_red(red),
    .o_led_green(grn));

  fbm_master_model i_fbm_master_model (
    .i_mclk(clk), .o_wr_valid(wv), .o_wr_data(wd), .o_wr_last(wl),
    .o_rd_start(rs), .o_rd_len(rn), .i_rd_valid(rv), .o_rd_ready(rr),
    .i_rd_data(rd), .i_rd_last(rl));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input string nm, input logic [15:0] x,
                     input logic [15:0] g);
    checks_done++;
    if (g !== x) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  task automatic end_of_test();
    if (failures == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  // table pattern: distinct per byte so misplaced bytes show
  function automatic logic [7:0] tb(input int a);
    return 8'(a * 7 + 3);
  endfunction : tb

  // network write into the input table, held until the arbiter grants it
  task automatic nw_wr(input int a, input logic [7:0] v);
    int t;
    t = 0;
    iw = 1'b1;
    ia = FBM_ADDR_W'(a);
    idt = v;
    do begin
      @(posedge clk);
      t++;
    end while (!ir && t < 50);
    #1;
    iw = 1'b0;
    tick();
  endtask : nw_wr

  // network read of the output table; answer one cycle after the grant
  task automatic nw_rd(input int a, output logic [7:0] v);
    orr = 1'b1;
    oa = FBM_ADDR_W'(a);
    tick();
    orr = 1'b0;
    @(posedge clk);
    chk("nw_out_valid", 16'h1, {15'h0, ov});
    v = od;
    #1;
  endtask : nw_rd

  task automatic cmpq(input logic [7:0] x[$]);
    chk("rd_count", 16'(x.size()), 16'(q.size()));
    chk("rd_last", 16'h1, {15'h0, ok});
    foreach (x[i]) begin
      if (i < q.size()) chk("rd_byte", {8'h0, x[i]}, {8'h0, q[i]});
    end
  endtask : cmpq

  // cycles with red and with green lit over n cycles; n is one full pattern
  task automatic led_cnt(input int n, input int r, input int g);
    int nr;
    int ng;
    nr = 0;
    ng = 0;
    repeat (n) begin
      tick();
      nr += (red === 1'b1);
      ng += (grn === 1'b1);
    end
    chk("led_red_on", 16'(r), 16'(nr));
    chk("led_green_on", 16'(g), 16'(ng));
  endtask : led_cnt

  // green toggles and red level over n cycles
  task automatic led_chk(input int n, input int tog);
    int t;
    logic g0;
    t = 0;
    g0 = grn;
    repeat (n) begin
      tick();
      if (grn !== g0) t++;
      g0 = grn;
      chk("led_red", 16'h0, {15'h0, red});
    end
    chk("led_toggles", 16'(tog), 16'(t));
  endtask : led_chk

  // count command pulses; the network side is held off during master bytes
  always @(posedge clk) begin
    if (fc === 1'b1) fc_n++;
    if (mr === 1'b1) mr_n++;
    if (wv === 1'b1) chk("nw_out_ready", 16'h0, {15'h0, oor});
  end

  // watchdog sized well above the few hundred cycles the tests need
  initial begin
    #100us;
    failures++;
    end_of_test();
  end

  // main sequence
  initial begin
    rst = 1'b1;
    {sw, hd, iw, orr, be, bo, ro, idn, da, stt, mjf} = '0;
    {ia, oa, idt, fe, ns, fid} = '0;
    tick(3);
    rst = 1'b0;
    tick(2);
    chk("led_init", 16'h3, {14'h0, red, grn});
    for (int a = 0; a < 64; a++) nw_wr(a, tb(a));
    e = {};
    for (int i = 0; i < 20; i++) e.push_back(tb(i));
    i_fbm_master_model.fetch(20, 24, q, ok);
    cmpq(e);
    sw = 1'b1;
    e = {};
    for (int i = 0; i < 6; i++) e.push_back(tb(i ^ 1));
    i_fbm_master_model.fetch(6, 0, q, ok);
    cmpq(e);
    sw = 1'b0;
    hd = 1'b1;
    idn = 1'b1;
    ns = FBM_NW_ONLINE;
    tick(4);
    da = 1'b1;
    tick();
    da = 1'b0;
    tick();
    chk("diag_pending", 16'h0, {15'h0, dp});
    e = '{8'h02, 8'h00, 8'h01, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
    e = {e, 8'h00, 8'h00, 8'h00, 8'h00, tb(12), tb(13)};
    i_fbm_master_model.fetch(14, 0, q, ok);
    cmpq(e);
    fe = 7'h04;
    {bo, ro} = 2'b11;
    repeat (3) begin
      be = 1'b1;
      tick();
      {fe, bo, ro, be} = '0;
      tick();
    end
    tick(2);
    chk("diag_pending", 16'h1, {15'h0, dp});
    chk("diag_status", 16'h0006, ds);
    e = '{8'h06, 8'h00, 8'h01, 8'h80, 8'h04, 8'h00};
    e = {e, 8'h03, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00};
    i_fbm_master_model.fetch(12, 0, q, ok);
    cmpq(e);
    i_fbm_master_model.send('{8'h02, 8'h00, 8'h00, 8'h00});
    tick(4);
    chk("fault_clear", 16'h1, 16'(fc_n));
    e[0] = 8'h02;
    e[4] = 8'h00;
    e[6] = 8'h00;
    i_fbm_master_model.fetch(12, 0, q, ok);
    cmpq(e);
    i_fbm_master_model.send('{8'h13, 8'h0, 8'h0, 8'h0, 8'hA1, 8'hB2});
    tick(4);
    chk("run", 16'h1, {15'h0, run});
    chk("fault_clear", 16'h1, 16'(fc_n));
    chk("module_reset", 16'h1, 16'(mr_n));
    nw_rd(0, d);
    chk("out_cmd", 16'h13, {8'h0, d});
    nw_rd(5, d);
    chk("out_data", 16'hB2, {8'h0, d});
    chk("led_run", 16'h1, {15'h0, grn});
    led_chk(12, 0);
    i_fbm_master_model.send('{8'h11, 8'h00, 8'h00, 8'h00});
    tick(4);
    chk("module_reset", 16'h1, 16'(mr_n));
    i_fbm_master_model.send('{8'hEC, 8'hFF, 8'hFF, 8'hFF});
    tick(4);
    chk("run", 16'h0, {15'h0, run});
    chk("pulses", 16'h2, 16'(fc_n + mr_n));
    led_chk(4 * HALF, 4);
    sw = 1'b1;
    i_fbm_master_model.send('{8'h0, 8'h0, 8'h0, 8'h0, 8'h11, 8'h22});
    tick(2);
    nw_rd(4, d);
    chk("out_swap", 16'h22, {8'h0, d});
    // self-test: red, green, orange, one half period each
    stt = 1'b1;
    tick(HALF);
    led_cnt(3 * HALF, 2 * HALF, 2 * HALF);
    // fatal code 2: two red/green pairs, then four dark half periods
    stt = 1'b0;
    mjf = 1'b1;
    fid = 4'h2;
    tick(2 * HALF);
    led_cnt(8 * HALF, 2 * HALF, 2 * HALF);
    end_of_test();
  end
endmodule : fbm_io_table_mapper_bench
